/* design/pcicfg_pkg.sv */
package pcicfg_pkg;

   // ==========================================================
   // Configuration offsets (byte addresses in config space)
   localparam logic [7:0] OFS_CLASS_REV   = 8'h08;
   localparam logic [7:0] OFS_TIMER_LINE  = 8'h0c;
   localparam logic [7:0] OFS_HDR_KIND    = 8'h0e;
   localparam logic [7:0] OFS_WIN_BASE    = 8'h10;

   // ==========================================================
   // Fixed field values
   localparam logic [7:0] BASE_CATEGORY   = 8'h0c;
   localparam logic [7:0] SUB_CATEGORY    = 8'h00;
   localparam logic [7:0] PROG_MODEL_CODE = 8'h10;
   localparam logic [7:0] SELF_TEST_CODE  = 8'h00;
   localparam logic [7:0] LAYOUT_KIND     = 8'h00;

   // ==========================================================
   // Field positions
   localparam int CLS_BASE_LSB    = 24;
   localparam int CLS_SUB_LSB     = 16;
   localparam int CLS_PROG_LSB    = 8;
   localparam int TL_TIMER_LSB    = 8;
   localparam int HDR_TEST_LSB    = 8;
   localparam int WIN_BASE_LSB    = 12;
   localparam int WIN_BASE_W      = 20;

   // ==========================================================
   // Reset values and masks
   localparam logic [15:0] TIMER_LINE_RST = 16'h0000;
   localparam logic [19:0] WIN_BASE_RST   = 20'h00000;
   localparam logic [31:0] WIN_RO_ZERO    = 32'h0000_0fff;
   localparam logic [31:0] WIN_SIZE_READ  = 32'hffff_f000;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pcicfg_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } pcicfg_mem_t;

endpackage

/* design/pcicfg_tenure.sv */
`timescale 1ns/1ps

module pcicfg_tenure (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Control from the register bank
   input  wire logic [7:0] timer_value_i,
   // Bus master engine
   input  wire logic       frame_start_i,
   input  wire logic       xfer_active_i,
   input  wire logic       bus_grant_n_i,
   // Status
   output logic            expired_o,
   output logic            stop_o
);

   logic [7:0] count_reg;
   logic       run_reg;

   // ==========================================================
   // Tenure counter, restarted at every frame start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= 8'h00;
         run_reg   <= 1'b0;
      end else if (frame_start_i) begin
         count_reg <= 8'h00;
         run_reg   <= 1'b1;
      end else if (!xfer_active_i) begin
         run_reg   <= 1'b0;
      end else if (run_reg && count_reg != 8'hff) begin
         count_reg <= count_reg + 8'h01;
      end
   end

   // ==========================================================
   // Expiry and stop request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         expired_o <= 1'b0;
      end else if (frame_start_i) begin
         expired_o <= 1'b0;
      end else if (run_reg && count_reg >= timer_value_i) begin
         expired_o <= 1'b1;
      end
   end

   // Stop waits for grant loss so a granted master keeps its burst
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_o <= 1'b0;
      end else begin
         stop_o <= expired_o && xfer_active_i && bus_grant_n_i;
      end
   end

   AST_TENURE_RESTART: assert property (
      @(posedge clk_i) disable iff (rst_i)
      frame_start_i |=> count_reg == 8'h00)
      else $error("tenure count not cleared at frame start");

   AST_TENURE_COUNT: assert property (
      @(posedge clk_i) disable iff (rst_i)
      run_reg && xfer_active_i && !frame_start_i && count_reg != 8'hff
      |=> count_reg == $past(count_reg) + 8'h01)
      else $error("tenure count did not advance");

   AST_TENURE_STOP: assert property (
      @(posedge clk_i) disable iff (rst_i)
      expired_o && xfer_active_i && bus_grant_n_i |=> stop_o)
      else $error("transaction not ended after grant loss");

   AST_TENURE_HOLD: assert property (
      @(posedge clk_i) disable iff (rst_i)
      stop_o |-> $past(expired_o) && $past(xfer_active_i) &&
      $past(bus_grant_n_i))
      else $error("stop raised without expiry and grant loss");

endmodule

/* design/pcicfg_regs.sv */
`timescale 1ns/1ps

module pcicfg_regs #(
   // Arbitrary revision value, not tied to any part
   parameter logic [7:0] SILICON_REV_CODE = 8'h21
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Configuration access
   input  wire pcicfg_pkg::pcicfg_req_t  cfg_req_i,
   output logic                          cfg_ack_o,
   output logic [31:0]                   cfg_rdata_o,
   // EEPROM preload path
   input  wire logic                     eeprom_present_i,
   input  wire logic                     preload_valid_i,
   input  wire logic [15:0]              preload_data_i,
   // Memory window decode
   input  wire logic                     memory_decode_enable_i,
   input  wire pcicfg_pkg::pcicfg_mem_t  mem_req_i,
   output logic                          win_hit_o,
   output logic [31:0]                   host_ctrl_window_base_o,
   // Bus master engine
   input  wire logic                     frame_start_i,
   input  wire logic                     xfer_active_i,
   input  wire logic                     bus_grant_n_i,
   output logic [7:0]                    line_size_setting_o,
   output logic                          tenure_expired_o,
   output logic                          tenure_stop_o
);

   typedef enum logic [0:0] {
      PL_WAIT,
      PL_DONE
   } pcicfg_pl_t;

   pcicfg_pl_t  pl_state_reg;
   logic [7:0]  tenure_timer_reg;
   logic [7:0]  line_size_reg;
   logic [19:0] window_base_reg;
   logic [31:0] class_word;
   logic [31:0] timer_word;
   logic [31:0] window_word;
   logic [31:0] read_next;
   logic        wr_timer_line;
   logic        wr_window;

   // ==========================================================
   // Read-back words
   assign class_word  = {pcicfg_pkg::BASE_CATEGORY,
                         pcicfg_pkg::SUB_CATEGORY,
                         pcicfg_pkg::PROG_MODEL_CODE,
                         SILICON_REV_CODE};
   assign timer_word  = {pcicfg_pkg::SELF_TEST_CODE,
                         pcicfg_pkg::LAYOUT_KIND,
                         tenure_timer_reg,
                         line_size_reg};
   // Low twelve bits are hard zero, which is what sizes the window
   assign window_word = {window_base_reg, 12'h000};

   // ==========================================================
   // Write decode
   // The header kind halfword shares the dword at 0Ch; its lanes are
   // simply not decoded for write.
   assign wr_timer_line = cfg_req_i.wr &&
      cfg_req_i.addr[7:2] == pcicfg_pkg::OFS_TIMER_LINE[7:2];
   assign wr_window     = cfg_req_i.wr &&
      cfg_req_i.addr[7:2] == pcicfg_pkg::OFS_WIN_BASE[7:2];

   // ==========================================================
   // Preload sequencer, one pass after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pl_state_reg <= PL_WAIT;
      end else begin
         unique case (pl_state_reg)
            PL_WAIT: begin
               // A host write to the 0Ch word also closes the window so it is not
               // overwritten by a late preload
               if (!eeprom_present_i || preload_valid_i || wr_timer_line) begin
                  pl_state_reg <= PL_DONE;
               end
            end
            PL_DONE: begin
               pl_state_reg <= PL_DONE;
            end
         endcase
      end
   end

   // ==========================================================
   // Tenure timer and line size
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tenure_timer_reg <= pcicfg_pkg::TIMER_LINE_RST[15:8];
         line_size_reg    <= pcicfg_pkg::TIMER_LINE_RST[7:0];
      end else if (wr_timer_line) begin
         if (cfg_req_i.be[1]) begin
            tenure_timer_reg <= cfg_req_i.wdata[15:8];
         end
         if (cfg_req_i.be[0]) begin
            line_size_reg <= cfg_req_i.wdata[7:0];
         end
      end else if (pl_state_reg == PL_WAIT && eeprom_present_i &&
                   preload_valid_i) begin
         tenure_timer_reg <= preload_data_i[15:8];
         line_size_reg    <= preload_data_i[7:0];
      end
   end

   // ==========================================================
   // Window base, only bits 31:12 are storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         window_base_reg <= pcicfg_pkg::WIN_BASE_RST;
      end else if (wr_window) begin
         if (cfg_req_i.be[1]) begin
            window_base_reg[3:0] <= cfg_req_i.wdata[15:12];
         end
         if (cfg_req_i.be[2]) begin
            window_base_reg[11:4] <= cfg_req_i.wdata[23:16];
         end
         if (cfg_req_i.be[3]) begin
            window_base_reg[19:12] <= cfg_req_i.wdata[31:24];
         end
      end
   end

   // ==========================================================
   // Read mux and answer, one cycle after the request
   always_comb begin
      unique case (cfg_req_i.addr[7:2])
         pcicfg_pkg::OFS_CLASS_REV[7:2]:  read_next = class_word;
         pcicfg_pkg::OFS_TIMER_LINE[7:2]: read_next = timer_word;
         pcicfg_pkg::OFS_WIN_BASE[7:2]:   read_next = window_word;
         default:                         read_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_ack_o   <= 1'b0;
         cfg_rdata_o <= 32'h0000_0000;
      end else begin
         cfg_ack_o <= cfg_req_i.rd || cfg_req_i.wr;
         if (cfg_req_i.rd) begin
            cfg_rdata_o <= read_next;
         end
      end
   end

   // ==========================================================
   // Window decode and engine outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_hit_o               <= 1'b0;
         host_ctrl_window_base_o <= 32'h0000_0000;
         line_size_setting_o     <= 8'h00;
      end else begin
         win_hit_o <= mem_req_i.valid && memory_decode_enable_i &&
            mem_req_i.addr[31:12] == window_base_reg;
         host_ctrl_window_base_o <= window_word;
         line_size_setting_o     <= line_size_reg;
      end
   end

   pcicfg_tenure u_tenure (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .timer_value_i (tenure_timer_reg),
      .frame_start_i (frame_start_i),
      .xfer_active_i (xfer_active_i),
      .bus_grant_n_i (bus_grant_n_i),
      .expired_o     (tenure_expired_o),
      .stop_o        (tenure_stop_o)
   );

   // ==========================================================
   // Checks
   AST_CLASS_BASE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == pcicfg_pkg::OFS_CLASS_REV
      |=> cfg_rdata_o[31:24] == 8'h0c)
      else $error("base category not 0Ch");

   AST_CLASS_SUB: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == pcicfg_pkg::OFS_CLASS_REV
      |=> cfg_rdata_o[23:16] == 8'h00)
      else $error("sub category not 00h");

   AST_CLASS_PROG: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == pcicfg_pkg::OFS_CLASS_REV
      |=> cfg_rdata_o[15:8] == 8'h10 && cfg_ack_o)
      else $error("programming model code not 10h");

   AST_CLASS_REV: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == pcicfg_pkg::OFS_CLASS_REV
      |=> cfg_rdata_o[7:0] == SILICON_REV_CODE)
      else $error("silicon revision code wrong");

   AST_PRELOAD: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pl_state_reg == PL_WAIT && eeprom_present_i && preload_valid_i &&
      !wr_timer_line |=> {tenure_timer_reg, line_size_reg} ==
      $past(preload_data_i))
      else $error("preload not taken");

   // Without an EEPROM nothing but a host write may move the timer word
   AST_NO_EEPROM: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !eeprom_present_i && !wr_timer_line
      |=> $stable(tenure_timer_reg) && $stable(line_size_reg))
      else $error("timer word moved without EEPROM or write");

   AST_LINE_SIZE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_timer_line && cfg_req_i.be[0]
      |=> ##1 line_size_setting_o == $past(cfg_req_i.wdata[7:0], 2))
      else $error("line size not passed to engine");

   AST_HDR_KIND: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr[7:2] == pcicfg_pkg::OFS_HDR_KIND[7:2]
      |=> cfg_rdata_o[31:16] == 16'h0000)
      else $error("header kind or self-test not zero");

   AST_WIN_SIZE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr == pcicfg_pkg::OFS_WIN_BASE &&
      window_base_reg == 20'hfffff |=> cfg_rdata_o == 32'hffff_f000)
      else $error("window sizing readback wrong");

   AST_WIN_LOW: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_ack_o && $past(cfg_req_i.rd) &&
      $past(cfg_req_i.addr) == pcicfg_pkg::OFS_WIN_BASE
      |-> cfg_rdata_o[11:0] == 12'h000)
      else $error("window low bits not zero");

   AST_WIN_STORE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_window && cfg_req_i.be == 4'hf
      |=> ##1 host_ctrl_window_base_o[31:12] ==
      $past(cfg_req_i.wdata[31:12], 2))
      else $error("window base not stored");

   AST_DECODE_GATE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !memory_decode_enable_i |=> !win_hit_o)
      else $error("window hit while decode disabled");

   AST_RO_CLASS: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.wr && cfg_req_i.addr == pcicfg_pkg::OFS_CLASS_REV
      |=> $stable(window_base_reg) && $stable(line_size_reg) &&
      $stable(tenure_timer_reg))
      else $error("write to read-only word changed state");

   // ==========================================================
   // Handshake, read-only lanes, preload closing and decode
   AST_ACK_TAKEN: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd || cfg_req_i.wr |=> cfg_ack_o)
      else $error("configuration access not acknowledged");

   AST_ACK_IDLE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !cfg_req_i.rd && !cfg_req_i.wr |=> !cfg_ack_o)
      else $error("acknowledge without an access");

   AST_RDATA_HOLD: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !cfg_req_i.rd |=> $stable(cfg_rdata_o))
      else $error("read data changed without a read");

   // Everything from 20h upward is outside this bank
   AST_UNMAPPED_RD: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cfg_req_i.rd && cfg_req_i.addr[7:5] != 3'h0
      |=> cfg_rdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");

   AST_HDR_LANES: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_timer_line && cfg_req_i.be[1:0] == 2'b00
      |=> $stable(tenure_timer_reg) && $stable(line_size_reg))
      else $error("write to header kind lanes changed state");

   AST_WIN_LANE0: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_window && cfg_req_i.be[3:1] == 3'h0
      |=> $stable(window_base_reg))
      else $error("write to window low lane changed the base");

   AST_TIMER_WRITE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_timer_line && cfg_req_i.be[1]
      |=> tenure_timer_reg == $past(cfg_req_i.wdata[15:8]))
      else $error("tenure timer write not stored");

   AST_LINE_WRITE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wr_timer_line && cfg_req_i.be[0]
      |=> line_size_reg == $past(cfg_req_i.wdata[7:0]))
      else $error("line size write not stored");

   // A second preload pulse must not overwrite the first
   AST_PRELOAD_ONCE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pl_state_reg == PL_DONE && !wr_timer_line
      |=> $stable(tenure_timer_reg) && $stable(line_size_reg))
      else $error("timer word changed after preload closed");

   AST_PRELOAD_CLOSE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      pl_state_reg == PL_WAIT && !eeprom_present_i
      |=> pl_state_reg == PL_DONE)
      else $error("preload left open without EEPROM");

   AST_HIT_MATCH: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mem_req_i.valid && memory_decode_enable_i &&
      mem_req_i.addr[31:12] == window_base_reg |=> win_hit_o)
      else $error("window access inside base not decoded");

   AST_HIT_MISS: assert property (
      @(posedge clk_i) disable iff (rst_i)
      mem_req_i.valid && mem_req_i.addr[31:12] != window_base_reg
      |=> !win_hit_o)
      else $error("window hit outside the base");

   AST_HIT_IDLE: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !mem_req_i.valid |=> !win_hit_o)
      else $error("window hit without a memory request");

endmodule

/* testbench/pcicfg_host_model.sv */
`timescale 1ns/1ps

module pcicfg_host_model (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Configuration access
   output pcicfg_pkg::pcicfg_req_t cfg_req_o,
   input  wire logic            cfg_ack_i,
   input  wire logic [31:0]     cfg_rdata_i
);
   // ==========================================================
   // Configuration cycles
   initial cfg_req_o = '0;

   // Strobe is a one-cycle pulse, since the bank takes one access per
   // strobe; address, lanes and data stand until the ack is sampled
   task automatic access(input logic wr, input logic [7:0] addr,
                         input logic [3:0] be, input logic [31:0] wd,
                         output logic [31:0] rd, output logic ok);
      int n;
      ok = 1'h0;
      rd = '0;
      @(posedge clk_i);
      cfg_req_o <= '{rd: ~wr, wr: wr, addr: addr, be: be, wdata: wd};
      @(posedge clk_i);
      cfg_req_o.rd <= 1'h0;
      cfg_req_o.wr <= 1'h0;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge clk_i);
         if (cfg_ack_i === 1'h1) begin
            ok = 1'h1;
            rd = cfg_rdata_i;
         end
      end
      // Qualifiers flip once released so a late sampler sees no stale request
      cfg_req_o <= '{rd: 1'h0, wr: 1'h0, addr: ~addr, be: ~be, wdata: ~wd};
   endtask
endmodule

/* testbench/pci_config_header_regs_tb_top.sv */
`timescale 1ns/1ps

module pci_config_header_regs_tb_top;
   // Arbitrary revision value, not tied to any part
   localparam logic [7:0] REV = 8'h5a;
   localparam int EXPECT_CYC = 600;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wd;
      logic [31:0] exp;
   } pcicfg_row_t;

   logic clk_i, rst_i, cfg_ack, eeprom, pre_vld, mem_en, win_hit;
   logic frame_start, xfer_active, grant_n, expired, stop;
   logic [15:0] pre_data;
   logic [31:0] cfg_rdata, win_base, rd;
   logic [7:0]  line_size;
   pcicfg_pkg::pcicfg_req_t cfg_req;
   pcicfg_pkg::pcicfg_mem_t mem_req;
   int err_total = 0;
   int tests_run = 0;

   pcicfg_row_t rows [9] = '{
      '{1'h0, 8'h08, 4'h0, 32'h0, {8'h0c, 8'h00, 8'h10, REV}},
      '{1'h1, 8'h08, 4'hf, 32'hffff_ffff, {8'h0c, 8'h00, 8'h10, REV}},
      '{1'h1, 8'h0c, 4'hf, 32'hffff_ffff, 32'h0000_ffff},
      '{1'h1, 8'h0c, 4'h1, 32'h0000_0020, 32'h0000_ff20},
      '{1'h1, 8'h0e, 4'hc, 32'hffff_0000, 32'h0000_ff20},
      '{1'h1, 8'h10, 4'hf, 32'hffff_ffff, 32'hffff_f000},
      '{1'h1, 8'h10, 4'h2, 32'h0000_abcd, 32'hffff_a000},
      '{1'h1, 8'h10, 4'h1, 32'h0000_0fff, 32'hffff_a000},
      '{1'h1, 8'h20, 4'hf, 32'h1234_5678, 32'h0000_0000}
   };

   pcicfg_regs #(.SILICON_REV_CODE(REV)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(cfg_req),
      .cfg_ack_o(cfg_ack), .cfg_rdata_o(cfg_rdata),
      .eeprom_present_i(eeprom), .preload_valid_i(pre_vld),
      .preload_data_i(pre_data), .memory_decode_enable_i(mem_en),
      .mem_req_i(mem_req), .win_hit_o(win_hit),
      .host_ctrl_window_base_o(win_base), .frame_start_i(frame_start),
      .xfer_active_i(xfer_active), .bus_grant_n_i(grant_n),
      .line_size_setting_o(line_size), .tenure_expired_o(expired),
      .tenure_stop_o(stop)
   );

   pcicfg_host_model host (
      .clk_i(clk_i), .rst_i(rst_i), .cfg_req_o(cfg_req),
      .cfg_ack_i(cfg_ack), .cfg_rdata_i(cfg_rdata)
   );

   // ==========================================================
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cfg_rw(input logic wr, input logic [7:0] addr,
                         input logic [3:0] be, input logic [31:0] wd);
      logic ok;
      host.access(wr, addr, be, wd, rd, ok);
      check("cfg_ack", {31'h0, ok}, 32'h1);
   endtask

   task automatic do_reset(input logic present);
      @(posedge clk_i);
      rst_i <= 1'h1;
      eeprom <= present;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'h0;
   endtask

   task automatic preload(input logic [15:0] d);
      @(posedge clk_i);
      pre_vld <= 1'h1;
      pre_data <= d;
      @(posedge clk_i);
      pre_vld <= 1'h0;
      pre_data <= ~d;
   endtask

   task automatic probe(input logic [31:0] a, input logic exp);
      @(posedge clk_i);
      mem_req <= '{valid: 1'h1, addr: a};
      @(posedge clk_i);
      mem_req <= '{valid: 1'h0, addr: ~a};
      @(posedge clk_i);
      check("win_hit", {31'h0, win_hit}, {31'h0, exp});
   endtask

   // Expiry shows in the sample taken timer+3 edges after frame_start
   task automatic tenure(input logic [7:0] t);
      int n;
      cfg_rw(1'h1, 8'h0c, 4'h2, {16'h0, t, 8'h0});
      @(posedge clk_i);
      frame_start <= 1'h1;
      xfer_active <= 1'h1;
      grant_n <= 1'h0;
      @(posedge clk_i);
      frame_start <= 1'h0;
      n = 1;
      do begin
         @(posedge clk_i);
         n++;
         if (n == 2) check("exp_clear", {31'h0, expired}, 32'h0);
      end while (expired !== 1'h1 && n < 300);
      check("expiry_edge", n, t + 3);
      check("stop_granted", {31'h0, stop}, 32'h0);
      grant_n <= 1'h1;
      @(posedge clk_i);
      check("stop_early", {31'h0, stop}, 32'h0);
      @(posedge clk_i);
      check("stop_set", {31'h0, stop}, 32'h1);
      xfer_active <= 1'h0;
      grant_n <= 1'h0;
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      clk_i = 1'h0;
      forever #4 clk_i = ~clk_i;
   end

   initial begin
      #(EXPECT_CYC * 8 * 4);
      err_total++;
      give_verdict();
   end

   initial begin
      rst_i = 1'h1;
      eeprom = 1'h0;
      pre_vld = 1'h0;
      pre_data = 16'h0;
      mem_en = 1'h0;
      mem_req = '0;
      frame_start = 1'h0;
      xfer_active = 1'h0;
      grant_n = 1'h0;
      do_reset(1'h0);
      foreach (rows[i]) begin
         if (rows[i].wr) cfg_rw(1'h1, rows[i].addr, rows[i].be, rows[i].wd);
         cfg_rw(1'h0, rows[i].addr, 4'h0, 32'h0);
         check($sformatf("row%0d", i), rd, rows[i].exp);
      end
      check("line_size", {24'h0, line_size}, 32'h20);
      check("win_base", win_base, 32'hffff_a000);
      $display("test table done");
      // Decode is enabled after the window base is written
      cfg_rw(1'h1, 8'h10, 4'hf, 32'h1234_5000);
      mem_en <= 1'h1;
      probe(32'h1234_5abc, 1'h1);
      probe(32'h1234_5fff, 1'h1);
      probe(32'h1234_6000, 1'h0);
      probe(32'h1234_4fff, 1'h0);
      mem_en <= 1'h0;
      probe(32'h1234_5000, 1'h0);
      $display("test window done");
      tenure(8'h00);
      tenure(8'h05);
      $display("test tenure done");
      // Preload arriving without an EEPROM must be dropped
      do_reset(1'h0);
      check("line_rst", {24'h0, line_size}, 32'h0);
      preload(16'h4008);
      cfg_rw(1'h0, 8'h0c, 4'h0, 32'h0);
      check("no_eeprom", rd, 32'h0);
      cfg_rw(1'h0, 8'h10, 4'h0, 32'h0);
      check("base_rst", rd, 32'h0);
      do_reset(1'h1);
      preload(16'h4008);
      preload(16'h7777);
      cfg_rw(1'h0, 8'h0c, 4'h0, 32'h0);
      check("preload", rd, 32'h0000_4008);
      check("line_pre", {24'h0, line_size}, 32'h08);
      $display("test reset done");
      give_verdict();
   end
endmodule
